/* File: hw/lgps_top.sv */
// Overview of operation
// - Two-bit function select at bits 9:8
// - Function applies only to LED-enabled pins
// - Enable 0 gives GPIO, 1 gives LED
// - LED pins lose pull-up and input buffer
// - Code 11b push-pull, others open-drain/source
// - Strap high at reset means active low for open-drain/source
// - Polarity from hard reset level only
// - GPIO pins follow GPIO registers, no strap
// - Field defaults from straps at resets
// - EEPROM loader may replace strap defaults
// - Bits 31:10 and 7:6 read-only
`timescale 1ns/1ps
`default_nettype none
module lgps_top
   import lgps_pkg::*;
#(
   parameter int unsigned PIN_COUNT = 6
)
(
   input  wire logic                   clk_in,             // 250 MHz clock
   input  wire logic                   reset_in,           // Synchronous reset, power-on
   input  wire logic                   ce_in,              // Clock enable, freezes state when low
   input  wire logic                   reset_pin_low_in,   // Device reset pin, active low, async
   input  wire logic [LGPS_FUN_W-1:0]  fun_strap_in,       // Function strap pins
   input  wire logic [PIN_COUNT-1:0]   en_strap_in,        // Enable strap pins
   input  wire logic                   e2p_load_in,        // EEPROM loader override strobe
   input  wire logic [LGPS_FUN_W-1:0]  e2p_fun_in,         // EEPROM function value
   input  wire logic [PIN_COUNT-1:0]   e2p_en_in,          // EEPROM enable value
   input  wire logic [PIN_COUNT-1:0]   led_on_in,          // Indication active per pin
   input  wire logic [PIN_COUNT-1:0]   gpio_dir_in,        // GPIO direction, 1 output
   input  wire logic [PIN_COUNT-1:0]   gpio_data_in,       // GPIO output data
   input  wire logic [PIN_COUNT-1:0]   gpio_pp_in,         // GPIO buffer, 1 push-pull
   input  wire logic                   wb_cyc_in,          // Wishbone cycle
   input  wire logic                   wb_stb_in,          // Wishbone strobe
   input  wire logic                   wb_we_in,           // Wishbone write enable
   input  wire logic [3:0]             wb_sel_in,          // Wishbone byte selects
   input  wire logic [LGPS_ADR_W-1:0]  wb_adr_in,          // Wishbone byte address
   input  wire logic [31:0]            wb_dat_in,          // Wishbone write data
   output logic      [31:0]            wb_dat_out,         // Wishbone read data
   output logic                        wb_ack_out,         // Wishbone acknowledge
   input  wire logic [PIN_COUNT-1:0]   pad_in,             // Shared pin levels
   output logic      [PIN_COUNT-1:0]   pad_out,            // Shared pin drive level
   output logic      [PIN_COUNT-1:0]   pad_oe_n_out,       // Pin output enable, low drives
   output logic      [PIN_COUNT-1:0]   pad_pullup_out,     // Pull-up enable per pin
   output logic      [PIN_COUNT-1:0]   gpio_in_out,        // Synchronised pin level to GPIO
   output logic      [PIN_COUNT-1:0]   led_mode_out,       // Pin is an LED output
   output logic                        push_pull_out       // LED pins driven push-pull
);

   localparam int unsigned SYNC_W = PIN_COUNT + PIN_COUNT + LGPS_FUN_W + 1;

   if (PIN_COUNT < 1 || PIN_COUNT > LGPS_EN_W)
   begin : g_bad_pin_count
      $error("PIN_COUNT must be 1 to 6");
   end

   // Two-stage synchronisers for every pin input
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync1_d;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] sync2_d;

   always_comb
   begin
      sync1_d = sync1_q;
      sync2_d = sync2_q;
      if (ce_in)
      begin
         sync1_d = {reset_pin_low_in, fun_strap_in, en_strap_in, pad_in};
         sync2_d = sync1_q;
      end
   end

   always_ff @(posedge clk_in)
   begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
   end

   logic [PIN_COUNT-1:0]  pad_s;
   logic [PIN_COUNT-1:0]  en_strap_s;
   logic [LGPS_FUN_W-1:0] fun_strap_s;
   logic                  rst_pin_s;

   assign pad_s       = sync2_q[PIN_COUNT-1:0];
   assign en_strap_s  = sync2_q[2*PIN_COUNT-1:PIN_COUNT];
   assign fun_strap_s = sync2_q[2*PIN_COUNT+LGPS_FUN_W-1:2*PIN_COUNT];
   assign rst_pin_s   = sync2_q[SYNC_W-1];

   // Strap capture window: power-on reset or reset pin held low, plus the first cycle after either ends
   logic rst_pin_prev_q;
   logic rst_pin_prev_d;
   logic capture;
   logic pin_release;

   assign pin_release = rst_pin_s & ~rst_pin_prev_q;
   assign capture     = reset_in | ~rst_pin_s | pin_release;

   always_comb
   begin
      rst_pin_prev_d = rst_pin_prev_q;
      if (ce_in)
         rst_pin_prev_d = rst_pin_s;
      if (reset_in)
         rst_pin_prev_d = 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      rst_pin_prev_q <= rst_pin_prev_d;
   end

   // Configuration register and hard-strap polarity
   logic [LGPS_FUN_W-1:0] fun_q;
   logic [LGPS_FUN_W-1:0] fun_d;
   logic [PIN_COUNT-1:0]  en_q;
   logic [PIN_COUNT-1:0]  en_d;
   logic [PIN_COUNT-1:0]  pol_q;
   logic [PIN_COUNT-1:0]  pol_d;
   logic                  loaded_q;
   logic                  loaded_d;
   logic                  cfg_wr;

   assign cfg_wr = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out & (wb_adr_in == LGPS_CFG_ADR);

   always_comb
   begin
      fun_d    = fun_q;
      en_d     = en_q;
      pol_d    = pol_q;
      loaded_d = loaded_q;
      if (ce_in)
      begin
         if (capture)
         begin
            fun_d    = fun_strap_s;
            en_d     = en_strap_s;
            pol_d    = pad_s;
            loaded_d = 1'b0;
         end
         else if (e2p_load_in)
         begin
            fun_d    = e2p_fun_in;
            en_d     = e2p_en_in;
            loaded_d = 1'b1;
         end
         else if (cfg_wr)
         begin
            if (wb_sel_in[LGPS_EN_SEL_BIT])
               en_d = wb_dat_in[LGPS_EN_LSB +: PIN_COUNT];
            if (wb_sel_in[LGPS_FUN_SEL_BIT])
               fun_d = wb_dat_in[LGPS_FUN_LSB +: LGPS_FUN_W];
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      fun_q    <= fun_d;
      en_q     <= en_d;
      pol_q    <= pol_d;
      loaded_q <= loaded_d;
   end

   // Wishbone slave, one wait state, unmapped reads zero
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic [31:0] cfg_word;
   logic [31:0] status_word;

   always_comb
   begin
      cfg_word = LGPS_ZERO_WORD;
      cfg_word[LGPS_EN_LSB +: PIN_COUNT]  = en_q;
      cfg_word[LGPS_FUN_LSB +: LGPS_FUN_W] = fun_q;
      status_word = LGPS_ZERO_WORD;
      status_word[LGPS_ST_POL_LSB +: PIN_COUNT] = pol_q;
      status_word[LGPS_ST_LOADED_BIT]           = loaded_q;
      status_word[LGPS_ST_PAD_LSB +: PIN_COUNT] = pad_s;
   end

   always_comb
   begin
      ack_d  = ack_q;
      rdat_d = rdat_q;
      if (ce_in)
      begin
         ack_d  = wb_cyc_in & wb_stb_in & ~ack_q;
         rdat_d = LGPS_ZERO_WORD;
         if (wb_cyc_in & wb_stb_in & ~ack_q & ~wb_we_in)
         begin
            unique case (wb_adr_in)
               LGPS_CFG_ADR:    rdat_d = cfg_word;
               LGPS_STATUS_ADR: rdat_d = status_word;
               default:         rdat_d = LGPS_ZERO_WORD;
            endcase
         end
      end
      if (reset_in)
      begin
         ack_d  = 1'b0;
         rdat_d = LGPS_ZERO_WORD;
      end
   end

   always_ff @(posedge clk_in)
   begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
   end

   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdat_q;

   // Per-pin output selection
   logic                 push_pull;
   lgps_pad_t            cell_pad [PIN_COUNT];
   lgps_cell_in_t        cell_cfg [PIN_COUNT];

   assign push_pull = (fun_q == LGPS_FUN_PUSH_PULL);

   for (genvar i = 0; i < PIN_COUNT; i++)
   begin : g_pin
      always_comb
      begin
         cell_cfg[i].led_mode   = en_q[i];
         cell_cfg[i].push_pull  = push_pull;
         cell_cfg[i].active_low = pol_q[i];
         cell_cfg[i].led_on     = led_on_in[i];
         cell_cfg[i].gpio_dir   = gpio_dir_in[i];
         cell_cfg[i].gpio_data  = gpio_data_in[i];
         cell_cfg[i].gpio_pp    = gpio_pp_in[i];
      end

      lgps_pin_cell u_cell (
         .cfg_in  (cell_cfg[i]),
         .pad_out (cell_pad[i])
      );
   end

   // Registered pad controls; pins released during reset
   logic [PIN_COUNT-1:0] drv_q;
   logic [PIN_COUNT-1:0] drv_d;
   logic [PIN_COUNT-1:0] oe_n_q;
   logic [PIN_COUNT-1:0] oe_n_d;
   logic [PIN_COUNT-1:0] pu_q;
   logic [PIN_COUNT-1:0] pu_d;
   logic [PIN_COUNT-1:0] gin_q;
   logic [PIN_COUNT-1:0] gin_d;

   always_comb
   begin
      drv_d  = drv_q;
      oe_n_d = oe_n_q;
      pu_d   = pu_q;
      gin_d  = gin_q;
      if (ce_in)
      begin
         for (int j = 0; j < PIN_COUNT; j++)
         begin
            drv_d[j]  = cell_pad[j].drive;
            oe_n_d[j] = cell_pad[j].oe_n;
            pu_d[j]   = cell_pad[j].pullup_en;
            gin_d[j]  = cell_pad[j].inbuf_en & pad_s[j];
         end
      end
      if (capture)
      begin
         drv_d  = '0;
         oe_n_d = '1;
         pu_d   = '1;
         gin_d  = '0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      drv_q  <= drv_d;
      oe_n_q <= oe_n_d;
      pu_q   <= pu_d;
      gin_q  <= gin_d;
   end

   assign pad_out        = drv_q;
   assign pad_oe_n_out   = oe_n_q;
   assign pad_pullup_out = pu_q;
   assign gpio_in_out    = gin_q;
   assign led_mode_out   = en_q;
   assign push_pull_out  = push_pull;

endmodule
`default_nettype wire

/* File: hw/lgps_pkg.sv */
package lgps_pkg;

   // Register map, byte addresses on the Wishbone port
   localparam int unsigned LGPS_ADR_W          = 4;
   localparam logic [3:0]  LGPS_CFG_ADR        = 4'h0;
   localparam logic [3:0]  LGPS_STATUS_ADR     = 4'h4;

   // indicator_pin_config field layout
   localparam int unsigned LGPS_EN_LSB         = 0;
   localparam int unsigned LGPS_EN_W           = 6;
   localparam int unsigned LGPS_FUN_LSB        = 8;
   localparam int unsigned LGPS_FUN_W          = 2;
   localparam logic [1:0]  LGPS_FUN_PUSH_PULL  = 2'h3;

   // Status register field layout
   localparam int unsigned LGPS_ST_POL_LSB     = 0;
   localparam int unsigned LGPS_ST_LOADED_BIT  = 8;
   localparam int unsigned LGPS_ST_PAD_LSB     = 16;

   // Byte lanes holding each writable field
   localparam int unsigned LGPS_EN_SEL_BIT     = 0;
   localparam int unsigned LGPS_FUN_SEL_BIT    = 1;

   localparam logic [31:0] LGPS_ZERO_WORD      = 32'h0000_0000;
   localparam logic [1:0]  LGPS_SYNC_ZERO      = 2'h0;

   typedef struct packed {
      logic                  cyc;
      logic                  stb;
      logic                  we;
      logic [3:0]            sel;
      logic [LGPS_ADR_W-1:0] adr;
      logic [31:0]           dat;
   } lgps_wb_req_t;

   typedef struct packed {
      logic drive;     // Pin level when driven
      logic oe_n;      // Low while the pin is driven
      logic pullup_en; // Internal pull-up on
      logic inbuf_en;  // Input buffer on
   } lgps_pad_t;

   typedef struct packed {
      logic led_mode;
      logic push_pull;
      logic active_low;
      logic led_on;
      logic gpio_dir;
      logic gpio_data;
      logic gpio_pp;
   } lgps_cell_in_t;

endpackage

/* File: hw/lgps_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module lgps_pin_cell
   import lgps_pkg::*;
(
   input  wire lgps_cell_in_t cfg_in,   // Mode and data for this pin
   output lgps_pad_t          pad_out   // Resulting pad control
);

   always_comb
   begin
      pad_out = '{drive: 1'b0, oe_n: 1'b1, pullup_en: 1'b1, inbuf_en: 1'b1};
      if (cfg_in.led_mode)
      begin
         pad_out.pullup_en = 1'b0;
         pad_out.inbuf_en  = 1'b0;
         if (cfg_in.push_pull)
         begin
            pad_out.drive = cfg_in.led_on;
            pad_out.oe_n  = 1'b0;
         end
         else if (cfg_in.active_low)
         begin
            pad_out.drive = 1'b0;
            pad_out.oe_n  = ~cfg_in.led_on;
         end
         else
         begin
            pad_out.drive = 1'b1;
            pad_out.oe_n  = ~cfg_in.led_on;
         end
      end
      else if (cfg_in.gpio_dir)
      begin
         if (cfg_in.gpio_pp)
         begin
            pad_out.drive = cfg_in.gpio_data;
            pad_out.oe_n  = 1'b0;
         end
         else
         begin
            pad_out.drive = 1'b0;
            pad_out.oe_n  = cfg_in.gpio_data;
         end
      end
   end

endmodule
`default_nettype wire

/* File: sim/lgps_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lgps_pad_model #(
   parameter int unsigned PIN_COUNT = 6
)
(
   input  wire logic [PIN_COUNT-1:0] drive_in,  // Pad drive level
   input  wire logic [PIN_COUNT-1:0] oe_n_in,   // Low while driven
   input  wire logic [PIN_COUNT-1:0] bias_in,   // External strap resistors
   output logic      [PIN_COUNT-1:0] level_out  // Resolved pin level
);
   // Released pins settle to the external strap resistor
   assign level_out = (oe_n_in & bias_in) | (~oe_n_in & drive_in);
endmodule
`default_nettype wire

/* File: sim/lgps_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module lgps_monitor
   import lgps_pkg::*;
#(
   parameter int unsigned PIN_COUNT = 6
)
(
   input wire logic                  clk_in,
   input wire logic                  reset_in,
   input wire logic                  ce_in,
   input wire logic                  reset_pin_low_in,
   input wire logic                  wb_cyc_in,
   input wire logic                  wb_stb_in,
   input wire logic                  wb_we_in,
   input wire logic [LGPS_ADR_W-1:0] wb_adr_in,
   input wire logic [31:0]           wb_dat_out,
   input wire logic                  wb_ack_out,
   input wire logic [PIN_COUNT-1:0]  led_on_in,
   input wire logic [PIN_COUNT-1:0]  gpio_dir_in,
   input wire logic [PIN_COUNT-1:0]  gpio_data_in,
   input wire logic [PIN_COUNT-1:0]  gpio_pp_in,
   input wire logic [PIN_COUNT-1:0]  pad_out,
   input wire logic [PIN_COUNT-1:0]  pad_oe_n_out,
   input wire logic [PIN_COUNT-1:0]  pad_pullup_out,
   input wire logic [PIN_COUNT-1:0]  gpio_in_out,
   input wire logic [PIN_COUNT-1:0]  led_mode_out,
   input wire logic                  push_pull_out
);
   logic [2:0] up_q;
   logic [2:0] up_d;
   wire        rd_cfg = wb_ack_out && !wb_we_in && wb_adr_in == LGPS_CFG_ADR;
   wire        up = up_q == 3'h7;
   // Cycles since either reset, so pad checks skip capture and settling
   always_comb up_d = (reset_in || !reset_pin_low_in) ? 3'h0 : (up ? up_q : up_q + 3'h1);
   always_ff @(posedge clk_in) up_q <= up_d;
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   ack_once_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
   ack_time_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
      else $error("ack late");
   dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == LGPS_ZERO_WORD) else $error("data without ack");
   cfg_fields_a: assert property (rd_cfg |-> wb_dat_out[5:0] == led_mode_out
      && push_pull_out == (wb_dat_out[9:8] == LGPS_FUN_PUSH_PULL)) else $error("fields differ from pins");
   cfg_rsvd_a: assert property (rd_cfg |-> wb_dat_out[31:10] == 22'h0 && wb_dat_out[7:6] == 2'h0)
      else $error("reserved bits set");
   led_quiet_a: assert property (up |-> !(|(led_mode_out & $past(led_mode_out)
      & (pad_pullup_out | gpio_in_out)))) else $error("LED pin has pull-up or input");
   led_pp_a: assert property (up && push_pull_out && $past(push_pull_out) |-> !(|(led_mode_out
      & $past(led_mode_out) & (pad_oe_n_out | (pad_out ^ $past(led_on_in)))))) else $error("push-pull LED");
   led_od_a: assert property (up && !push_pull_out && !$past(push_pull_out) |-> !(|(led_mode_out
      & $past(led_mode_out) & ~$past(led_on_in) & ~pad_oe_n_out))) else $error("idle LED driven");
   gpio_pp_a: assert property (up |-> !(|(~led_mode_out & ~$past(led_mode_out) & $past(gpio_dir_in)
      & $past(gpio_pp_in) & (pad_oe_n_out | (pad_out ^ $past(gpio_data_in)))))) else $error("GPIO drive");
   cover property (rd_cfg);
   cover property (push_pull_out && |led_mode_out);
   cover property (wb_ack_out && wb_we_in);
endmodule
bind lgps_top lgps_monitor #(.PIN_COUNT(PIN_COUNT)) mon_u (.clk_in, .reset_in, .ce_in, .reset_pin_low_in,
   .wb_cyc_in, .wb_stb_in,
   .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .led_on_in, .gpio_dir_in, .gpio_data_in, .gpio_pp_in,
   .pad_out, .pad_oe_n_out, .pad_pullup_out, .gpio_in_out, .led_mode_out, .push_pull_out);
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lgps_pkg::*;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        reset_pin_low_in = 1'b1;
   logic [1:0]  fun_strap_in = 2'h1;
   logic [5:0]  en_strap_in = 6'h2D;
   logic        e2p_load_in = 1'b0;
   logic [1:0]  e2p_fun_in = 2'h2;
   logic [5:0]  e2p_en_in = 6'h15;
   logic [5:0]  led_on_in = 6'h00;
   logic [5:0]  gpio_dir_in = 6'h00;
   logic [5:0]  gpio_data_in = 6'h00;
   logic [5:0]  gpio_pp_in = 6'h00;
   logic        wb_cyc_in = 1'b0;
   logic        wb_stb_in = 1'b0;
   logic        wb_we_in = 1'b0;
   logic [3:0]  wb_sel_in = 4'h0;
   logic [3:0]  wb_adr_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0;
   logic [5:0]  bias = 6'h0F;
   logic [31:0] wb_dat_out;
   logic        wb_ack_out;
   logic [5:0]  pad_in;
   logic [5:0]  pad_out;
   logic [5:0]  pad_oe_n_out;
   logic [5:0]  pad_pullup_out;
   logic [5:0]  gpio_in_out;
   logic [5:0]  led_mode_out;
   logic        push_pull_out;
   int          mismatches = 0;
   int          n_tests = 0;

   lgps_top dut_u (.clk_in, .reset_in, .ce_in(1'b1), .reset_pin_low_in, .fun_strap_in, .en_strap_in,
      .e2p_load_in, .e2p_fun_in, .e2p_en_in, .led_on_in, .gpio_dir_in, .gpio_data_in, .gpio_pp_in,
      .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_sel_in, .wb_adr_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
      .pad_in, .pad_out, .pad_oe_n_out, .pad_pullup_out, .gpio_in_out, .led_mode_out, .push_pull_out);
   lgps_pad_model pads_u (.drive_in(pad_out), .oe_n_in(pad_oe_n_out), .bias_in(bias), .level_out(pad_in));

   initial
   begin
      forever #2 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_sel_in <= s;
      wb_dat_in <= d;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (wb_ack_out !== 1'b1 && n < 20);
      r = wb_dat_out;
      chk(32'(wb_ack_out), 32'h1);
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] r;
      wb(1'b0, a, 4'hF, 32'h0, r);
      chk(r & m, e);
   endtask

   task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, s, d, r);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (3000) @(posedge clk_in);
      mismatches++;
      tally_and_finish();
   end

   initial
   begin
      repeat (10) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      rd(LGPS_CFG_ADR, 32'h0000_012D, 32'hFFFF_FFFF);
      rd(LGPS_STATUS_ADR, 32'h0000_000F, 32'h0000_01FF);
      wr(LGPS_CFG_ADR, 4'hF, 32'hFFFF_FFFF);
      rd(LGPS_CFG_ADR, 32'h0000_033F, 32'hFFFF_FFFF);
      wr(LGPS_CFG_ADR, 4'h2, 32'h0);
      rd(LGPS_CFG_ADR, 32'h0000_003F, 32'hFFFF_FFFF);
      rd(4'hC, 32'h0, 32'hFFFF_FFFF);
      led_on_in <= 6'h33;
      for (int f = 0; f < 4; f++)
      begin
         wr(LGPS_CFG_ADR, 4'h2, {22'h0, f[1:0], 8'h0});
         repeat (3) @(posedge clk_in);
         chk(32'(push_pull_out), 32'(f == 3));
         chk(32'(pad_oe_n_out), f == 3 ? 32'h0 : 32'h0C);
         chk(32'(pad_out & ~pad_oe_n_out), f == 3 ? 32'h33 : 32'h30);
         chk(32'(pad_pullup_out | gpio_in_out), 32'h0);
      end
      gpio_dir_in <= 6'h03;
      gpio_pp_in <= 6'h01;
      gpio_data_in <= 6'h01;
      wr(LGPS_CFG_ADR, 4'h3, 32'h0000_003C);
      repeat (3) @(posedge clk_in);
      chk(32'(led_mode_out), 32'h3C);
      chk(32'({pad_oe_n_out[1:0], pad_out[1:0]}), 32'h1);
      gpio_data_in <= 6'h02;
      repeat (3) @(posedge clk_in);
      chk(32'({pad_oe_n_out[1:0], pad_out[0]}), 32'h4);
      @(posedge clk_in);
      e2p_load_in <= 1'b1;
      @(posedge clk_in);
      e2p_load_in <= 1'b0;
      rd(LGPS_CFG_ADR, 32'h0000_0215, 32'hFFFF_FFFF);
      rd(LGPS_STATUS_ADR, 32'h0000_010F, 32'h0000_01FF);
      fun_strap_in <= 2'h3;
      en_strap_in <= 6'h07;
      reset_pin_low_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      reset_pin_low_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      rd(LGPS_CFG_ADR, 32'h0000_0307, 32'hFFFF_FFFF);
      rd(LGPS_STATUS_ADR, 32'h0, 32'h0000_0100);
      tally_and_finish();
   end
endmodule
`default_nettype wire
